// ### ecp_pkg.sv
// Constants, register map and shared types of the external control port.
package ecp_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned ECP_NCMD = 7;
    localparam int unsigned ECP_ADDR_W = 8;
    localparam int unsigned ECP_NLIM = 4;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ECP_OFF_CTRL = 8'h00;
    localparam logic [7:0] ECP_OFF_STAT = 8'h04;
    localparam logic [7:0] ECP_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] ECP_OFF_IRQ_EN = 8'h0c;
    localparam logic [7:0] ECP_OFF_IRQ_CLR = 8'h10;
    localparam logic [7:0] ECP_OFF_LIM = 8'h14;

    // ==========================================================
    // Control register fields
    localparam int unsigned ECP_CTRL_OUT = 0;
    localparam int unsigned ECP_CTRL_BUSY = 1;
    localparam int unsigned ECP_CTRL_SYNC = 2;
    localparam int unsigned ECP_CTRL_OUT_WE = 4;

    // ==========================================================
    // Status register fields
    localparam int unsigned ECP_ST_OUT = 0;
    localparam int unsigned ECP_ST_PWR = 1;
    localparam int unsigned ECP_ST_LIM = 2;
    localparam int unsigned ECP_ST_BUSY = 3;
    localparam int unsigned ECP_ST_SEQ = 4;
    localparam int unsigned ECP_ST_PIN = 8;

    // ==========================================================
    // Reset values and bus encodings
    localparam logic [ECP_NCMD-1:0] ECP_PIN_IDLE = 7'h7f;
    localparam logic [ECP_NCMD-1:0] ECP_IRQ_EN_RST = 7'h00;
    localparam logic [1:0] ECP_SYNC_RST = 2'h0;
    localparam logic [1:0] ECP_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] ECP_HSIZE_WORD = 3'h2;
    localparam logic ECP_HRESP_OKAY = 1'h0;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ECP_SEQ_IDLE,
        ECP_SEQ_RUN,
        ECP_SEQ_HOLD
    } ecp_seq_t;

    typedef struct packed {
        logic branch2;
        logic branch1;
        logic hold;
        logic stop;
        logic start;
        logic out_on;
        logic out_off;
    } ecp_cmd_t;

    typedef struct packed {
        logic [1:0] seq_sync;
        logic busy;
        logic lim;
        logic out_on;
        logic pwr_on;
    } ecp_stat_t;

endpackage

// ### ecp_cmd_sync.sv
// Synchroniser and falling-edge detector for the command inputs.
`timescale 1ns/10ps
module ecp_cmd_sync #(
    parameter int unsigned N = ecp_pkg::ECP_NCMD
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw pins, active low
    input wire logic [N-1:0] pin_n,
    // Synchronised levels and edge pulses
    output logic [N-1:0] level,
    output logic [N-1:0] fall
);

    // ==========================================================
    // Three-stage chain: two for metastability, one for edges.
    logic [N-1:0] s1_q, s2_q, s3_q;
    logic [N-1:0] s1_d, s2_d, s3_d;

    // The idle pattern is only as wide as the package's command count.
    if (N < 1 || N > ecp_pkg::ECP_NCMD) begin : g_bad_n
        $error("ecp_cmd_sync: N out of range");
    end

    always_comb begin
        s1_d = pin_n;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= ecp_pkg::ECP_PIN_IDLE[N-1:0];
            s2_q <= ecp_pkg::ECP_PIN_IDLE[N-1:0];
            s3_q <= ecp_pkg::ECP_PIN_IDLE[N-1:0];
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    assign level = s2_q;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_edge
            assign fall[i] = s3_q[i] & ~s2_q[i];
        end
    endgenerate

    // ==========================================================
    // Checks
    AST_FALL_SINGLE: assert property (@(posedge clk) disable iff (rst)
        (fall != '0) |=> ((fall & $past(fall)) == '0))
        else $error("edge pulse lasted more than one cycle");

    AST_LEVEL_NO_PULSE: assert property (@(posedge clk) disable iff (rst)
        ((~level & ~$past(level) & fall) == '0))
        else $error("pulse raised while input was held low");

endmodule // ecp_cmd_sync

// ### ecp_seq_ctl.sv
// Sequence run, hold and stop state kept from the external commands.
`timescale 1ns/10ps
module ecp_seq_ctl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command pulses
    input wire logic start,
    input wire logic stop,
    input wire logic hold,
    // Sequence state
    output ecp_pkg::ecp_seq_t state
);

    ecp_pkg::ecp_seq_t st_q, st_d;

    // Stop beats start, start beats hold, so a stop is never lost.
    always_comb begin
        st_d = st_q;
        case (st_q)
            ecp_pkg::ECP_SEQ_IDLE: begin
                if (start && !stop) begin
                    st_d = ecp_pkg::ECP_SEQ_RUN;
                end
            end
            ecp_pkg::ECP_SEQ_RUN: begin
                if (stop) begin
                    st_d = ecp_pkg::ECP_SEQ_IDLE;
                end else if (hold && !start) begin
                    st_d = ecp_pkg::ECP_SEQ_HOLD;
                end
            end
            ecp_pkg::ECP_SEQ_HOLD: begin
                if (stop) begin
                    st_d = ecp_pkg::ECP_SEQ_IDLE;
                end else if (start) begin
                    st_d = ecp_pkg::ECP_SEQ_RUN;
                end
            end
            default: begin
                st_d = ecp_pkg::ECP_SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ecp_pkg::ECP_SEQ_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign state = st_q;

    AST_SEQ_STOP: assert property (@(posedge clk) disable iff (rst)
        stop |=> (st_q == ecp_pkg::ECP_SEQ_IDLE))
        else $error("stop did not return sequence to idle");

endmodule // ecp_seq_ctl

// ### ecp_ext_io.sv
// Top of the external control port with its AHB-Lite register slave.
`timescale 1ns/10ps
module ecp_ext_io (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Command pins, active low
    input wire logic [ecp_pkg::ECP_NCMD-1:0] cmd_pin_n,
    // Status pins
    output ecp_pkg::ecp_stat_t stat_pin,
    // Instrument state
    input wire logic pwr_good,
    input wire logic lim_pk_pos,
    input wire logic lim_pk_neg,
    input wire logic lim_avg,
    input wire logic lim_pwr,
    // Command pulses and sequence state to the instrument
    output ecp_pkg::ecp_cmd_t cmd_pulse,
    output ecp_pkg::ecp_seq_t seq_state,
    // Interrupt
    output logic irq
);

    localparam int unsigned NC = ecp_pkg::ECP_NCMD;
    localparam int unsigned AW = ecp_pkg::ECP_ADDR_W;

    // ==========================================================
    // Command inputs
    logic [NC-1:0] pin_level;
    logic [NC-1:0] pin_fall;
    ecp_pkg::ecp_cmd_t cmd;

    ecp_cmd_sync #(
        .N(NC)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pin_n(cmd_pin_n),
        .level(pin_level),
        .fall(pin_fall)
    );

    assign cmd = ecp_pkg::ecp_cmd_t'(pin_fall);
    assign cmd_pulse = cmd;

    ecp_seq_ctl u_seq (
        .clk(clk),
        .rst(rst),
        .start(cmd.start),
        .stop(cmd.stop),
        .hold(cmd.hold),
        .state(seq_state)
    );

    // ==========================================================
    // Bus address phase capture
    logic wr_pend_q, wr_pend_d;
    logic [AW-1:0] wr_addr_q, wr_addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic addr_ph;
    logic wr_now;

    function automatic logic [31:0] read_mux(input logic [AW-1:0] a,
            input logic [31:0] ctrl, input logic [31:0] st,
            input logic [31:0] ist, input logic [31:0] ien,
            input logic [31:0] lim);
        logic [31:0] r;
        r = '0;
        case (a)
            ecp_pkg::ECP_OFF_CTRL: r = ctrl;
            ecp_pkg::ECP_OFF_STAT: r = st;
            ecp_pkg::ECP_OFF_IRQ_STAT: r = ist;
            ecp_pkg::ECP_OFF_IRQ_EN: r = ien;
            ecp_pkg::ECP_OFF_LIM: r = lim;
            default: r = '0;
        endcase
        return r;
    endfunction

    function automatic logic hit(input logic [AW-1:0] a,
            input logic [7:0] off);
        return a == off;
    endfunction

    assign addr_ph = hsel && hready && (htrans == ecp_pkg::ECP_HTRANS_NONSEQ)
        && (hsize == ecp_pkg::ECP_HSIZE_WORD);
    assign wr_now = wr_pend_q;

    // ==========================================================
    // Software state
    logic out_en_q, out_en_d;
    logic busy_q, busy_d;
    logic [1:0] sync_q, sync_d;
    logic [NC-1:0] ist_q, ist_d;
    logic [NC-1:0] ien_q, ien_d;
    logic pwr_q, pwr_d;
    logic lim_q, lim_d;
    logic [ecp_pkg::ECP_NLIM-1:0] lim_v_q, lim_v_d;
    logic irq_q, irq_d;
    logic [31:0] ctrl_rd, st_rd, ist_rd, ien_rd, lim_rd;
    logic [31:0] wd;

    assign wd = hwdata;

    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[ecp_pkg::ECP_CTRL_OUT] = out_en_q;
        ctrl_rd[ecp_pkg::ECP_CTRL_BUSY] = busy_q;
        ctrl_rd[ecp_pkg::ECP_CTRL_SYNC +: 2] = sync_q;
        st_rd = '0;
        st_rd[ecp_pkg::ECP_ST_OUT] = out_en_q;
        st_rd[ecp_pkg::ECP_ST_PWR] = pwr_q;
        st_rd[ecp_pkg::ECP_ST_LIM] = lim_q;
        st_rd[ecp_pkg::ECP_ST_BUSY] = busy_q;
        st_rd[ecp_pkg::ECP_ST_SEQ +: 2] = seq_state;
        st_rd[ecp_pkg::ECP_ST_PIN +: NC] = pin_level;
        ist_rd = '0;
        ist_rd[NC-1:0] = ist_q;
        ien_rd = '0;
        ien_rd[NC-1:0] = ien_q;
        lim_rd = '0;
        lim_rd[ecp_pkg::ECP_NLIM-1:0] = lim_v_q;
    end

    always_comb begin
        wr_pend_d = addr_ph && hwrite;
        wr_addr_d = addr_ph ? haddr[AW-1:0] : wr_addr_q;
        rdata_d = rdata_q;
        if (addr_ph && !hwrite) begin
            rdata_d = read_mux(haddr[AW-1:0], ctrl_rd, st_rd, ist_rd,
                ien_rd, lim_rd);
        end
    end

    // Pin commands win over a software write to the output enable in the
    // same cycle, and an off command wins over an on command.
    always_comb begin
        out_en_d = out_en_q;
        busy_d = busy_q;
        sync_d = sync_q;
        ien_d = ien_q;
        if (wr_now && hit(wr_addr_q, ecp_pkg::ECP_OFF_CTRL)) begin
            if (wd[ecp_pkg::ECP_CTRL_OUT_WE]) begin
                out_en_d = wd[ecp_pkg::ECP_CTRL_OUT];
            end
            busy_d = wd[ecp_pkg::ECP_CTRL_BUSY];
            sync_d = wd[ecp_pkg::ECP_CTRL_SYNC +: 2];
        end
        if (wr_now && hit(wr_addr_q, ecp_pkg::ECP_OFF_IRQ_EN)) begin
            ien_d = wd[NC-1:0];
        end
        if (cmd.out_on) begin
            out_en_d = 1'b1;
        end
        if (cmd.out_off) begin
            out_en_d = 1'b0;
        end
        if (!pwr_q) begin
            out_en_d = 1'b0;
        end
    end

    // Sticky events: a new edge in the clearing cycle survives the clear.
    always_comb begin
        ist_d = ist_q;
        if (wr_now && hit(wr_addr_q, ecp_pkg::ECP_OFF_IRQ_CLR)) begin
            ist_d = ist_q & ~wd[NC-1:0];
        end
        ist_d = ist_d | pin_fall;
        pwr_d = pwr_good;
        lim_v_d = {lim_pwr, lim_avg, lim_pk_neg, lim_pk_pos};
        lim_d = |lim_v_d;
        irq_d = |(ist_q & ien_q);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            rdata_q <= '0;
            out_en_q <= 1'b0;
            busy_q <= 1'b0;
            sync_q <= ecp_pkg::ECP_SYNC_RST;
            ist_q <= '0;
            ien_q <= ecp_pkg::ECP_IRQ_EN_RST;
            pwr_q <= 1'b0;
            lim_q <= 1'b0;
            lim_v_q <= '0;
            irq_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q <= rdata_d;
            out_en_q <= out_en_d;
            busy_q <= busy_d;
            sync_q <= sync_d;
            ist_q <= ist_d;
            ien_q <= ien_d;
            pwr_q <= pwr_d;
            lim_q <= lim_d;
            lim_v_q <= lim_v_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================================
    // Outputs: status pins always driven straight from flip-flops.
    assign stat_pin.pwr_on = pwr_q;
    assign stat_pin.out_on = out_en_q;
    assign stat_pin.lim = lim_q;
    assign stat_pin.busy = busy_q;
    assign stat_pin.seq_sync = sync_q;
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = ecp_pkg::ECP_HRESP_OKAY;
    assign irq = irq_q;

    // ==========================================================
    // Checks
    AST_PWR_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
        ##1 (stat_pin.pwr_on == $past(pwr_good)))
        else $error("power status does not follow power state");

    AST_OUT_OFF_CMD: assert property (@(posedge clk) disable iff (rst)
        cmd.out_off |=> !stat_pin.out_on)
        else $error("output status high after off command");

    AST_OUT_ON_CMD: assert property (@(posedge clk) disable iff (rst)
        (cmd.out_on && !cmd.out_off && pwr_q) |=> stat_pin.out_on)
        else $error("output status low after on command");

    AST_LIM_ANY: assert property (@(posedge clk) disable iff (rst)
        (lim_pk_pos || lim_pk_neg || lim_avg || lim_pwr) |=> stat_pin.lim)
        else $error("limiter status missed an active limiter");

    AST_LIM_NONE: assert property (@(posedge clk) disable iff (rst)
        !(lim_pk_pos || lim_pk_neg || lim_avg || lim_pwr) |=> !stat_pin.lim)
        else $error("limiter status high with no limiter");

    AST_BUSY_WRITE: assert property (@(posedge clk) disable iff (rst)
        (wr_pend_q && wr_addr_q == ecp_pkg::ECP_OFF_CTRL)
        |=> (stat_pin.busy == $past(hwdata[ecp_pkg::ECP_CTRL_BUSY])))
        else $error("busy status does not match control write");

    AST_SYNC_HOLD: assert property (@(posedge clk) disable iff (rst)
        !wr_pend_q |=> $stable(stat_pin.seq_sync))
        else $error("sync bits changed without a write");

    AST_STAT_MATCH: assert property (@(posedge clk) disable iff (rst)
        (addr_ph && !hwrite && haddr[AW-1:0] == ecp_pkg::ECP_OFF_STAT)
        |=> (hrdata[ecp_pkg::ECP_ST_OUT] == $past(stat_pin.out_on)))
        else $error("status register and status pin disagree");

    AST_EVENT_STICKY: assert property (@(posedge clk) disable iff (rst)
        (pin_fall != '0) |=> ((ist_q & $past(pin_fall)) == $past(pin_fall)))
        else $error("edge event not recorded");

    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (rst)
        ((ist_q & ien_q) != '0) |=> irq)
        else $error("interrupt not raised for enabled event");

    AST_IRQ_QUIET: assert property (@(posedge clk) disable iff (rst)
        ((ist_q & ien_q) == '0) |=> !irq)
        else $error("interrupt raised with no enabled event");

    AST_OUT_PWR_OFF: assert property (@(posedge clk) disable iff (rst)
        !pwr_q |=> !stat_pin.out_on)
        else $error("output status high while power is off");

    AST_OUT_HOLD: assert property (@(posedge clk) disable iff (rst)
        (pwr_q && !cmd.out_on && !cmd.out_off && !wr_pend_q)
        |=> (stat_pin.out_on == $past(stat_pin.out_on)))
        else $error("output status changed with no command");

    AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (rst)
        !wr_pend_q |=> $stable(stat_pin.busy))
        else $error("busy status changed without a write");

    AST_STAT_PWR: assert property (@(posedge clk) disable iff (rst)
        (addr_ph && !hwrite && haddr[AW-1:0] == ecp_pkg::ECP_OFF_STAT)
        |=> (hrdata[ecp_pkg::ECP_ST_PWR] == $past(stat_pin.pwr_on)))
        else $error("status register power bit disagrees with pin");

    AST_STAT_LIM: assert property (@(posedge clk) disable iff (rst)
        (addr_ph && !hwrite && haddr[AW-1:0] == ecp_pkg::ECP_OFF_STAT)
        |=> (hrdata[ecp_pkg::ECP_ST_LIM] == $past(stat_pin.lim)))
        else $error("status register limiter bit disagrees with pin");

    AST_STAT_BUSY: assert property (@(posedge clk) disable iff (rst)
        (addr_ph && !hwrite && haddr[AW-1:0] == ecp_pkg::ECP_OFF_STAT)
        |=> (hrdata[ecp_pkg::ECP_ST_BUSY] == $past(stat_pin.busy)))
        else $error("status register busy bit disagrees with pin");

    // A clear with no new edge in the same cycle must empty the bits.
    AST_IST_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (wr_pend_q && wr_addr_q == ecp_pkg::ECP_OFF_IRQ_CLR
            && pin_fall == '0)
        |=> ((ist_q & $past(hwdata[NC-1:0])) == '0))
        else $error("event bits not cleared by a clear write");

endmodule // ecp_ext_io

// ### ecp_ctl_model.sv
// Behavioural outside controller that drives the command pins.
`timescale 1ns/10ps
module ecp_ctl_model (
    // Clock
    input wire logic clk,
    // Command pins, pulled up, active low
    output logic [ecp_pkg::ECP_NCMD-1:0] cmd_pin_n
);
    // ==========================================================
    // Pin driver
    initial begin
        cmd_pin_n = ecp_pkg::ECP_PIN_IDLE;
    end

    // Pulls one pin low for lo cycles, then drives it high again.
    task automatic press(input int b, input int lo);
        @(posedge clk);
        cmd_pin_n[b] <= 1'b0;
        repeat (lo) @(posedge clk);
        cmd_pin_n[b] <= 1'b1;
        // The pin stays high long enough to be seen before another edge.
        repeat (3) @(posedge clk);
    endtask
endmodule // ecp_ctl_model

// ### ecp_ext_io_tb.sv
// Self-checking testbench of the external control port.
`timescale 1ns/10ps
module ecp_ext_io_tb;
    // ==========================================================
    // Signals
    logic clk;
    logic rst;
    logic hsel;
    logic hwrite;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic pwr_good;
    logic [3:0] lim;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [ecp_pkg::ECP_NCMD-1:0] cmd_pin_n;
    ecp_pkg::ecp_stat_t stat_pin;
    ecp_pkg::ecp_cmd_t cmd_pulse;
    ecp_pkg::ecp_seq_t seq_state;
    ecp_pkg::ecp_seq_t exp_seq;
    int failures;
    int checks;
    int pcnt[7];
    int pexp[7];
    int q[$] = '{1, 0, 1, 2, 4, 2, 4, 3, 5, 6};
    int exp_out;
    int exp_ist;
    int m;
    int v;
    int b;

    assign hready = hreadyout;

    ecp_ext_io DUT (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmd_pin_n(cmd_pin_n),
        .stat_pin(stat_pin), .pwr_good(pwr_good), .lim_pk_pos(lim[0]),
        .lim_pk_neg(lim[1]), .lim_avg(lim[2]), .lim_pwr(lim[3]),
        .cmd_pulse(cmd_pulse), .seq_state(seq_state), .irq(irq)
    );

    ecp_ctl_model u_ctl (
        .clk(clk),
        .cmd_pin_n(cmd_pin_n)
    );

    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= ecp_pkg::ECP_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= ecp_pkg::ECP_HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", hresp, ecp_pkg::ECP_HRESP_OKAY);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(1'b1, a, d, dummy);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string nm);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(nm, r, e);
    endtask

    // Settles on a falling edge so registered outputs are stable.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, pulse counter and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        for (int i = 0; i < 7; i++) begin
            if (rst === 1'b0 && cmd_pulse[i] === 1'b1) begin
                pcnt[i]++;
            end
        end
    end

    initial begin
        #300000;
        failures++;
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial begin
        failures = 0;
        checks = 0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        pwr_good = 1'b0;
        lim = 4'h0;
        exp_out = 0;
        exp_ist = 0;
        exp_seq = ecp_pkg::ECP_SEQ_IDLE;
        void'($urandom(7558));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        chk("stat_pin", 32'(stat_pin), 32'h0);
        rdchk(ecp_pkg::ECP_OFF_STAT, 32'h7f00, "stat");
        rdchk(ecp_pkg::ECP_OFF_IRQ_EN, 32'(ecp_pkg::ECP_IRQ_EN_RST), "ien");
        rdchk(8'h20, 32'h0, "unmapped");
        @(posedge clk);
        pwr_good <= 1'b1;
        tick(2);
        chk("pwr_on", stat_pin.pwr_on, 32'h1);
        for (int i = 0; i < 8; i++) begin
            v = $urandom_range(15);
            @(posedge clk);
            lim <= v[3:0];
            tick(3);
            chk("lim", stat_pin.lim, 32'(|v[3:0]));
            rdchk(ecp_pkg::ECP_OFF_LIM, 32'(v), "lim_reg");
        end
        for (int i = 0; i < 4; i++) begin
            v = $urandom_range(7);
            wr(ecp_pkg::ECP_OFF_CTRL, 32'(v << 1));
            tick(2);
            chk("busy", stat_pin.busy, 32'(v[0]));
            chk("sync", stat_pin.seq_sync, 32'(v[2:1]));
        end
        m = $urandom_range(1, 127);
        wr(ecp_pkg::ECP_OFF_IRQ_EN, 32'(m));
        wr(ecp_pkg::ECP_OFF_IRQ_CLR, 32'h7f);
        foreach (q[i]) begin
            b = q[i];
            u_ctl.press(b, $urandom_range(3, 9));
            tick(5);
            pexp[b]++;
            exp_ist |= 1 << b;
            case (b)
                0: exp_out = 0;
                1: exp_out = 1;
                2: exp_seq = ecp_pkg::ECP_SEQ_RUN;
                3: exp_seq = ecp_pkg::ECP_SEQ_IDLE;
                4: if (exp_seq == ecp_pkg::ECP_SEQ_RUN) begin
                    exp_seq = ecp_pkg::ECP_SEQ_HOLD;
                end
                default: ;
            endcase
            for (int j = 0; j < 7; j++) begin
                chk("pulses", 32'(pcnt[j]), 32'(pexp[j]));
            end
            chk("out_on", stat_pin.out_on, 32'(exp_out));
            chk("seq", 32'(seq_state), 32'(exp_seq));
            chk("irq", irq, 32'((exp_ist & m) != 0));
            rdchk(ecp_pkg::ECP_OFF_IRQ_STAT, 32'(exp_ist), "ist");
        end
        wr(ecp_pkg::ECP_OFF_IRQ_EN, 32'h0);
        tick(2);
        chk("irq_masked", irq, 32'h0);
        wr(ecp_pkg::ECP_OFF_IRQ_EN, 32'h7f);
        tick(2);
        chk("irq_on", irq, 32'h1);
        wr(ecp_pkg::ECP_OFF_IRQ_CLR, 32'h7f);
        tick(2);
        chk("irq_clr", irq, 32'h0);
        rdchk(ecp_pkg::ECP_OFF_IRQ_STAT, 32'h0, "ist_clr");
        @(posedge clk);
        pwr_good <= 1'b0;
        tick(3);
        chk("pwr_off", stat_pin.pwr_on, 32'h0);
        chk("out_forced", stat_pin.out_on, 32'h0);
        @(posedge clk);
        pwr_good <= 1'b1;
        tick(3);
        wr(ecp_pkg::ECP_OFF_CTRL, 32'h11);
        tick(2);
        chk("out_sw", stat_pin.out_on, 32'h1);
        rdchk(ecp_pkg::ECP_OFF_CTRL, 32'h1, "ctrl");
        conclude();
    end
endmodule // ecp_ext_io_tb
